// ===== core/tcpsc_pkg.sv
// Types of the session controller: states, frame kinds, link and configuration bundles
package tcpsc_pkg;
    typedef enum logic [4:0] {
        ST_RESET    = 5'b00000, ST_ARP_REQ  = 5'b00001, ST_ARP_WREP = 5'b00010,
        ST_ARP_WREQ = 5'b00011, ST_ARP_REP  = 5'b00100, ST_IDLE     = 5'b00101,
        ST_OPEN_SYN = 5'b00110, ST_OPEN_W   = 5'b00111, ST_FIN_ACK  = 5'b01000,
        ST_CLOSE_F  = 5'b01001, ST_CLOSE_W  = 5'b01010, ST_PSV_SA   = 5'b01011,
        ST_PSV_W    = 5'b01100, ST_PSV_FIN  = 5'b01101, ST_PSV_CW   = 5'b01110,
        ST_SEND_F   = 5'b01111, ST_SEND_R   = 5'b10000, ST_RES_2    = 5'b10001,
        ST_WAIT_ACK = 5'b10010
    } tcpsc_state_type;
    typedef enum logic [2:0] {
        K_ARP_REQ = 3'b000, K_ARP_REP = 3'b001, K_SYN = 3'b010, K_SYN_ACK = 3'b011,
        K_ACK     = 3'b100, K_FIN     = 3'b101, K_DATA = 3'b110
    } tcpsc_kind_type;
    typedef struct packed {
        logic        arp_reply;
        logic        arp_request;
        logic        syn;
        logic        syn_ack;
        logic        fin;
        logic        ack;
        logic [31:0] ack_num;
        logic [47:0] src_mac;
        logic [15:0] src_port;
    } tcpsc_rx_type;
    typedef struct packed {
        logic           valid;
        tcpsc_kind_type kind;
        logic [31:0]    seq;
        logic [31:0]    len;
        logic [15:0]    port;
    } tcpsc_tx_type;
    typedef struct packed {
        logic        eng_rst;
        logic [1:0]  role_select;
        logic [31:0] local_mac_low;
        logic [15:0] local_mac_high;
        logic [31:0] peer_mac_low;
        logic [15:0] peer_mac_high;
        logic [31:0] local_ip_addr;
        logic [31:0] peer_ip_addr;
        logic [15:0] local_port_num;
        logic [15:0] peer_port_num;
        logic [31:0] total_tx_length;
        logic [31:0] segment_size;
        logic        push_setting;
    } tcpsc_cfg_type;
    typedef struct packed {
        logic [47:0] local_mac;
        logic [47:0] peer_mac;
        logic [31:0] local_ip;
        logic [31:0] peer_ip;
        logic [15:0] local_port;
    } tcpsc_net_type;
endpackage

// ===== core/tcpsc_regs.svh
// Register offsets, field positions, reset values and command codes of the session controller
`ifndef TCPSC_REGS_SVH
`define TCPSC_REGS_SVH
`define TCPSC_OFS_RESET    8'h00
`define TCPSC_OFS_CMD      8'h04
`define TCPSC_OFS_ROLE     8'h08
`define TCPSC_OFS_LMAC_LO  8'h0C
`define TCPSC_OFS_LMAC_HI  8'h10
`define TCPSC_OFS_PMAC_LO  8'h14
`define TCPSC_OFS_PMAC_HI  8'h18
`define TCPSC_OFS_LIP      8'h1C
`define TCPSC_OFS_PIP      8'h20
`define TCPSC_OFS_LPORT    8'h24
`define TCPSC_OFS_PPORT    8'h28
`define TCPSC_OFS_TDL      8'h2C
`define TCPSC_OFS_PKL      8'h30
`define TCPSC_OFS_PUSH     8'h34
`define TCPSC_OFS_STATUS   8'h38
`define TCPSC_RESET_INIT   1'b1
`define TCPSC_BUSY_BIT     0
`define TCPSC_CONN_BIT     1
`define TCPSC_PUSH_BIT     0
`define TCPSC_CMD_SEND     2'h1
`define TCPSC_CMD_OPEN     2'h2
`define TCPSC_CMD_CLOSE    2'h3
`define TCPSC_ISN          32'h0000_0000
`endif

// ===== core/tcpsc_session_ctrl.sv
// Session controller: AHB-Lite registers, address resolution, open, close and segmented send
`timescale 1ns/1ns
`include "tcpsc_regs.svh"
module tcpsc_session_ctrl (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    input  wire tcpsc_pkg::tcpsc_rx_type rx_evt,
    input  wire logic [31:0]           payload_level,
    input  wire logic                  tx_ready,
    output tcpsc_pkg::tcpsc_tx_type    tx_req,
    output tcpsc_pkg::tcpsc_net_type   net_params,
    output logic                       connection_up
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic covers(input logic [31:0] ack, input logic [31:0] tgt);
        logic [31:0] diff;
        diff   = ack - tgt;
        covers = ~diff[31];
    endfunction

    function automatic tcpsc_pkg::tcpsc_tx_type mk_tx(input tcpsc_pkg::tcpsc_kind_type k,
        input logic [31:0] s, input logic [31:0] l, input logic [15:0] p);
        tcpsc_pkg::tcpsc_tx_type t;
        t.valid = 1'b1;
        t.kind  = k;
        t.seq   = s;
        t.len   = l;
        t.port  = p;
        mk_tx   = t;
    endfunction

    // ****************************************
    // Register bus
    // ****************************************
    tcpsc_pkg::tcpsc_cfg_type cfg_q,  cfg_d;
    logic                     pend_q, pend_d;
    logic                     wr_q,   wr_d;
    logic [7:0]               addr_q, addr_d;
    logic                     rdy_q,  rdy_d;
    logic [31:0]              rdata_q, rdata_d;
    logic                     cmd_go_q, cmd_go_d;
    logic [1:0]               cmd_q,  cmd_d;
    logic                     busy;
    tcpsc_pkg::tcpsc_state_type state_q, state_d;
    logic                     conn_q, conn_d;

    always_comb begin
        cfg_d    = cfg_q;
        pend_d   = 1'b0;
        wr_d     = wr_q;
        addr_d   = addr_q;
        rdy_d    = 1'b1;
        rdata_d  = rdata_q;
        cmd_go_d = 1'b0;
        cmd_d    = cmd_q;
        if (pend_q && wr_q) begin
            unique case (addr_q)
                `TCPSC_OFS_RESET:   cfg_d.eng_rst         = hwdata[0];
                `TCPSC_OFS_CMD: begin
                    cmd_go_d = ~cfg_q.eng_rst & ~busy;
                    cmd_d    = hwdata[1:0];
                end
                `TCPSC_OFS_ROLE:    cfg_d.role_select     = hwdata[1:0];
                `TCPSC_OFS_LMAC_LO: cfg_d.local_mac_low   = hwdata;
                `TCPSC_OFS_LMAC_HI: cfg_d.local_mac_high  = hwdata[15:0];
                `TCPSC_OFS_PMAC_LO: cfg_d.peer_mac_low    = hwdata;
                `TCPSC_OFS_PMAC_HI: cfg_d.peer_mac_high   = hwdata[15:0];
                `TCPSC_OFS_LIP:     cfg_d.local_ip_addr   = hwdata;
                `TCPSC_OFS_PIP:     cfg_d.peer_ip_addr    = hwdata;
                `TCPSC_OFS_LPORT:   cfg_d.local_port_num  = hwdata[15:0];
                `TCPSC_OFS_PPORT:   cfg_d.peer_port_num   = hwdata[15:0];
                `TCPSC_OFS_TDL:     cfg_d.total_tx_length = hwdata;
                `TCPSC_OFS_PKL:     cfg_d.segment_size    = hwdata;
                `TCPSC_OFS_PUSH:    cfg_d.push_setting    = hwdata[`TCPSC_PUSH_BIT];
                default: ;
            endcase
        end else if (pend_q) begin
            unique case (addr_q)
                `TCPSC_OFS_RESET:   rdata_d = {31'h0, cfg_q.eng_rst};
                `TCPSC_OFS_ROLE:    rdata_d = {30'h0, cfg_q.role_select};
                `TCPSC_OFS_LMAC_LO: rdata_d = cfg_q.local_mac_low;
                `TCPSC_OFS_LMAC_HI: rdata_d = {16'h0, cfg_q.local_mac_high};
                `TCPSC_OFS_PMAC_LO: rdata_d = cfg_q.peer_mac_low;
                `TCPSC_OFS_PMAC_HI: rdata_d = {16'h0, cfg_q.peer_mac_high};
                `TCPSC_OFS_LIP:     rdata_d = cfg_q.local_ip_addr;
                `TCPSC_OFS_PIP:     rdata_d = cfg_q.peer_ip_addr;
                `TCPSC_OFS_LPORT:   rdata_d = {16'h0, cfg_q.local_port_num};
                `TCPSC_OFS_PPORT:   rdata_d = {16'h0, cfg_q.peer_port_num};
                `TCPSC_OFS_TDL:     rdata_d = cfg_q.total_tx_length;
                `TCPSC_OFS_PKL:     rdata_d = cfg_q.segment_size;
                `TCPSC_OFS_PUSH:    rdata_d = {31'h0, cfg_q.push_setting};
                `TCPSC_OFS_STATUS:  rdata_d = {30'h0, conn_q, busy};
                default:            rdata_d = 32'h0000_0000;
            endcase
        end else if (hsel && htrans[1] && hready) begin
            pend_d = 1'b1;
            rdy_d  = 1'b0;
            wr_d   = hwrite;
            addr_d = {haddr[7:2], 2'b00};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q         <= '0;
            cfg_q.eng_rst <= `TCPSC_RESET_INIT;
            pend_q        <= 1'b0;
            wr_q          <= 1'b0;
            addr_q        <= 8'h00;
            rdy_q         <= 1'b1;
            rdata_q       <= 32'h0000_0000;
            cmd_go_q      <= 1'b0;
            cmd_q         <= 2'h0;
        end else begin
            cfg_q    <= cfg_d;
            pend_q   <= pend_d;
            wr_q     <= wr_d;
            addr_q   <= addr_d;
            rdy_q    <= rdy_d;
            rdata_q  <= rdata_d;
            cmd_go_q <= cmd_go_d;
            cmd_q    <= cmd_d;
        end
    end

    // ****************************************
    // Session engine
    // ****************************************
    tcpsc_pkg::tcpsc_tx_type tx_q, tx_d;
    logic [31:0]             seq_q, seq_d;
    logic [31:0]             rem_q, rem_d;
    logic [31:0]             ack_q, ack_d;
    logic [47:0]             pmac_q, pmac_d;
    logic                    up_next_q, up_next_d;
    logic [15:0]             rport_q, rport_d;
    logic                    tx_free;
    logic                    full_left;

    assign tx_free   = ~tx_q.valid;
    assign full_left = (cfg_q.segment_size != 32'h0000_0000) && (rem_q >= cfg_q.segment_size);
    assign busy      = cmd_go_q || !(state_q inside {tcpsc_pkg::ST_IDLE, tcpsc_pkg::ST_PSV_SA,
                       tcpsc_pkg::ST_PSV_W, tcpsc_pkg::ST_PSV_FIN, tcpsc_pkg::ST_PSV_CW});

    always_comb begin
        state_d   = state_q;
        tx_d      = tx_q;
        seq_d     = seq_q;
        rem_d     = rem_q;
        ack_d     = rx_evt.ack ? rx_evt.ack_num : ack_q;
        pmac_d    = pmac_q;
        conn_d    = conn_q;
        up_next_d = up_next_q;
        rport_d   = rport_q;
        if (tx_ready) begin
            tx_d.valid = 1'b0;
        end
        unique case (state_q)
            tcpsc_pkg::ST_RESET: begin
                seq_d  = `TCPSC_ISN;
                ack_d  = `TCPSC_ISN;
                conn_d = 1'b0;
                if (!cfg_q.eng_rst) begin
                    if (cfg_q.role_select[1]) begin
                        pmac_d  = {cfg_q.peer_mac_high, cfg_q.peer_mac_low};
                        state_d = tcpsc_pkg::ST_IDLE;
                    end else if (cfg_q.role_select[0]) begin
                        state_d = tcpsc_pkg::ST_ARP_WREQ;
                    end else begin
                        state_d = tcpsc_pkg::ST_ARP_REQ;
                    end
                end
            end
            tcpsc_pkg::ST_ARP_REQ: if (tx_free) begin
                tx_d    = mk_tx(tcpsc_pkg::K_ARP_REQ, seq_q, 32'h0, 16'h0);
                state_d = tcpsc_pkg::ST_ARP_WREP;
            end
            tcpsc_pkg::ST_ARP_WREP: if (rx_evt.arp_reply) begin
                pmac_d  = rx_evt.src_mac;
                state_d = tcpsc_pkg::ST_IDLE;
            end
            tcpsc_pkg::ST_ARP_WREQ: if (rx_evt.arp_request) begin
                pmac_d  = rx_evt.src_mac;
                state_d = tcpsc_pkg::ST_ARP_REP;
            end
            tcpsc_pkg::ST_ARP_REP: if (tx_free) begin
                tx_d    = mk_tx(tcpsc_pkg::K_ARP_REP, seq_q, 32'h0, 16'h0);
                state_d = tcpsc_pkg::ST_IDLE;
            end
            tcpsc_pkg::ST_IDLE: begin
                if (cmd_go_q && cmd_q == `TCPSC_CMD_OPEN && !conn_q) begin
                    rport_d = cfg_q.peer_port_num;
                    state_d = tcpsc_pkg::ST_OPEN_SYN;
                end else if (cmd_go_q && cmd_q == `TCPSC_CMD_CLOSE && conn_q) begin
                    state_d = tcpsc_pkg::ST_CLOSE_F;
                end else if (cmd_go_q && cmd_q == `TCPSC_CMD_SEND && conn_q) begin
                    rem_d   = cfg_q.total_tx_length;
                    state_d = tcpsc_pkg::ST_SEND_F;
                end else if (rx_evt.syn && !conn_q) begin
                    rport_d = rx_evt.src_port;
                    state_d = tcpsc_pkg::ST_PSV_SA;
                end else if (rx_evt.fin && conn_q) begin
                    state_d = tcpsc_pkg::ST_PSV_FIN;
                end
            end
            tcpsc_pkg::ST_OPEN_SYN: if (tx_free) begin
                tx_d    = mk_tx(tcpsc_pkg::K_SYN, seq_q, 32'h0, rport_q);
                seq_d   = seq_q + 32'h0000_0001;
                state_d = tcpsc_pkg::ST_OPEN_W;
            end
            tcpsc_pkg::ST_OPEN_W: if (rx_evt.syn_ack) begin
                up_next_d = 1'b1;
                state_d   = tcpsc_pkg::ST_FIN_ACK;
            end
            tcpsc_pkg::ST_FIN_ACK: if (tx_free) begin
                tx_d    = mk_tx(tcpsc_pkg::K_ACK, seq_q, 32'h0, rport_q);
                conn_d  = up_next_q;
                state_d = tcpsc_pkg::ST_IDLE;
            end
            tcpsc_pkg::ST_CLOSE_F: if (tx_free) begin
                tx_d    = mk_tx(tcpsc_pkg::K_FIN, seq_q, 32'h0, rport_q);
                seq_d   = seq_q + 32'h0000_0001;
                state_d = tcpsc_pkg::ST_CLOSE_W;
            end
            tcpsc_pkg::ST_CLOSE_W: if (rx_evt.fin) begin
                up_next_d = 1'b0;
                state_d   = tcpsc_pkg::ST_FIN_ACK;
            end
            tcpsc_pkg::ST_PSV_SA: if (tx_free) begin
                tx_d    = mk_tx(tcpsc_pkg::K_SYN_ACK, seq_q, 32'h0, rport_q);
                seq_d   = seq_q + 32'h0000_0001;
                state_d = tcpsc_pkg::ST_PSV_W;
            end
            tcpsc_pkg::ST_PSV_W: if (rx_evt.ack && covers(rx_evt.ack_num, seq_q)) begin
                conn_d  = 1'b1;
                state_d = tcpsc_pkg::ST_IDLE;
            end
            tcpsc_pkg::ST_PSV_FIN: if (tx_free) begin
                tx_d    = mk_tx(tcpsc_pkg::K_FIN, seq_q, 32'h0, rport_q);
                seq_d   = seq_q + 32'h0000_0001;
                state_d = tcpsc_pkg::ST_PSV_CW;
            end
            tcpsc_pkg::ST_PSV_CW: if (rx_evt.ack && covers(rx_evt.ack_num, seq_q)) begin
                conn_d  = 1'b0;
                state_d = tcpsc_pkg::ST_IDLE;
            end
            tcpsc_pkg::ST_SEND_F: begin
                if (!full_left) begin
                    state_d = tcpsc_pkg::ST_WAIT_ACK;
                end else if (tx_free && payload_level >= cfg_q.segment_size) begin
                    tx_d  = mk_tx(tcpsc_pkg::K_DATA, seq_q, cfg_q.segment_size, rport_q);
                    seq_d = seq_q + cfg_q.segment_size;
                    rem_d = rem_q - cfg_q.segment_size;
                end
            end
            tcpsc_pkg::ST_WAIT_ACK: if (covers(ack_q, seq_q)) begin
                state_d = (rem_q == 32'h0000_0000) ? tcpsc_pkg::ST_IDLE : tcpsc_pkg::ST_SEND_R;
            end
            tcpsc_pkg::ST_SEND_R: if (tx_free && payload_level >= rem_q) begin
                tx_d    = mk_tx(tcpsc_pkg::K_DATA, seq_q, rem_q, rport_q);
                state_d = cfg_q.push_setting ? tcpsc_pkg::ST_WAIT_ACK : tcpsc_pkg::ST_RES_2;
                if (cfg_q.push_setting) begin
                    seq_d = seq_q + rem_q;
                    rem_d = 32'h0000_0000;
                end
            end
            tcpsc_pkg::ST_RES_2: if (tx_free) begin
                tx_d    = mk_tx(tcpsc_pkg::K_DATA, seq_q, rem_q, rport_q);
                seq_d   = seq_q + rem_q;
                rem_d   = 32'h0000_0000;
                state_d = tcpsc_pkg::ST_WAIT_ACK;
            end
            default: state_d = tcpsc_pkg::ST_RESET;
        endcase
        if (cfg_q.eng_rst) begin
            state_d = tcpsc_pkg::ST_RESET;
            conn_d  = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= tcpsc_pkg::ST_RESET;
            tx_q      <= '0;
            seq_q     <= `TCPSC_ISN;
            rem_q     <= 32'h0000_0000;
            ack_q     <= 32'h0000_0000;
            pmac_q    <= 48'h0000_0000_0000;
            conn_q    <= 1'b0;
            up_next_q <= 1'b0;
            rport_q   <= 16'h0000;
        end else begin
            state_q   <= state_d;
            tx_q      <= tx_d;
            seq_q     <= seq_d;
            rem_q     <= rem_d;
            ack_q     <= ack_d;
            pmac_q    <= pmac_d;
            conn_q    <= conn_d;
            up_next_q <= up_next_d;
            rport_q   <= rport_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            net_params <= '0;
        end else begin
            net_params <= {{cfg_d.local_mac_high, cfg_d.local_mac_low}, pmac_d,
                           cfg_d.local_ip_addr, cfg_d.peer_ip_addr, cfg_d.local_port_num};
        end
    end

    assign hreadyout     = rdy_q;
    assign hrdata        = rdata_q;
    assign hresp         = 1'b0;
    assign tx_req        = tx_q;
    assign connection_up = conn_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_fin_out;
        tx_q.valid && tx_q.kind == tcpsc_pkg::K_FIN;
    endsequence
    sequence s_idle_again;
        state_q == tcpsc_pkg::ST_IDLE && !busy;
    endsequence

    a_fixed_mac_load: assert property (state_q == tcpsc_pkg::ST_RESET && !cfg_q.eng_rst && cfg_q.role_select[1]
        |=> s_idle_again ##0 pmac_q == {cfg_q.peer_mac_high, cfg_q.peer_mac_low}) else $error("fixed mac");
    a_client_arp_mac: assert property (state_q == tcpsc_pkg::ST_ARP_WREP && rx_evt.arp_reply && !cfg_q.eng_rst
        |=> pmac_q == $past(rx_evt.src_mac) && state_q == tcpsc_pkg::ST_IDLE) else $error("client arp");
    a_server_arp_reply: assert property (state_q == tcpsc_pkg::ST_ARP_REP && tx_free && !cfg_q.eng_rst
        |=> tx_q.valid && tx_q.kind == tcpsc_pkg::K_ARP_REP) else $error("server arp");
    a_open_syn_port: assert property (state_q == tcpsc_pkg::ST_OPEN_SYN && tx_free && !cfg_q.eng_rst
        |=> tx_q.kind == tcpsc_pkg::K_SYN && tx_q.port == cfg_q.peer_port_num && busy) else $error("open syn");
    a_close_fin_busy: assert property (state_q == tcpsc_pkg::ST_CLOSE_F && tx_free && !cfg_q.eng_rst
        |=> s_fin_out ##0 busy) else $error("close fin");
    a_passive_up: assert property (state_q == tcpsc_pkg::ST_PSV_W && rx_evt.ack && covers(rx_evt.ack_num, seq_q)
        && !cfg_q.eng_rst |=> connection_up && !busy) else $error("passive open");
    a_passive_down: assert property (state_q == tcpsc_pkg::ST_PSV_CW && rx_evt.ack && covers(rx_evt.ack_num, seq_q)
        && !cfg_q.eng_rst |=> !connection_up) else $error("passive close");
    a_full_seg_len: assert property ($rose(tx_q.valid) && tx_q.kind == tcpsc_pkg::K_DATA
        && $past(state_q) == tcpsc_pkg::ST_SEND_F |-> tx_q.len == cfg_q.segment_size) else $error("seg len");
    a_residue_twice: assert property (state_q == tcpsc_pkg::ST_SEND_R && tx_free && payload_level >= rem_q
        && !cfg_q.push_setting && !cfg_q.eng_rst |=> state_q == tcpsc_pkg::ST_RES_2) else $error("residue");
    a_residue_waits: assert property (state_q == tcpsc_pkg::ST_WAIT_ACK && !covers(ack_q, seq_q) && !cfg_q.eng_rst
        |=> state_q == tcpsc_pkg::ST_WAIT_ACK && busy) else $error("early residue");
    a_send_done: assert property (state_q == tcpsc_pkg::ST_WAIT_ACK && covers(ack_q, seq_q) && rem_q == 32'h0
        && !cfg_q.eng_rst |=> s_idle_again) else $error("send done");
    a_status_busy: assert property (pend_q && !wr_q && addr_q == `TCPSC_OFS_STATUS
        |=> hrdata[`TCPSC_BUSY_BIT] == $past(busy) && hreadyout) else $error("status busy");
endmodule

// ===== testbench/tcp_session_control_tb.sv
// Session controller bench: bus tasks and session scenarios
`timescale 1ns/1ns
`include "tcpsc_regs.svh"
module tcp_session_control_tb;
    logic                     hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic                     slow = 0, syn_in = 0, fin_in = 0, arp_in = 0;
    logic [1:0]               htrans = 2'h0;
    logic [31:0]              haddr = 32'h0, hwdata = 32'h0, pay = 32'h0, rdv;
    wire logic                hreadyout, hresp, tx_ready, conn;
    wire logic [31:0]         hrdata;
    wire tcpsc_pkg::tcpsc_tx_type  tx_req;
    wire tcpsc_pkg::tcpsc_rx_type  rx_evt;
    wire tcpsc_pkg::tcpsc_net_type net;
    int                       err_total = 0, tests_run = 0, nack = 0;
    logic [31:0]              lens[$], acks[$];
    always #10 hclk = !hclk;
    tcpsc_session_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .rx_evt(rx_evt), .payload_level(pay), .tx_ready(tx_ready),
        .tx_req(tx_req), .net_params(net), .connection_up(conn));
    tcpsc_peer u_peer (.hclk(hclk), .hresetn(hresetn), .tx_req(tx_req), .slow(slow), .syn_in(syn_in),
        .fin_in(fin_in), .arp_in(arp_in), .tx_ready(tx_ready), .rx_evt(rx_evt));
    always @(posedge hclk) begin
        if (tx_req.valid && tx_ready && tx_req.kind == tcpsc_pkg::K_DATA) begin
            lens.push_back(tx_req.len);
            acks.push_back(32'(nack));
        end
        if (rx_evt.ack) nack++;
    end
    task automatic report_and_stop();
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rdv);
    endtask
    task automatic idle();
        do bus(1'b0, `TCPSC_OFS_STATUS, 32'h0); while (rdv[0] !== 1'b0);
    endtask
    task automatic upw(input logic v);
        for (int i = 0; i < 200 && conn !== v; i++) @(posedge hclk);
        chk("conn", {31'h0, v}, {31'h0, conn});
    endtask
    task automatic snd(input logic [31:0] t, input logic [31:0] p, input logic ps, input logic late);
        int n;
        n = t / p;
        lens.delete();
        acks.delete();
        nack = 0;
        pay <= late ? 32'h0 : 32'h0001_0000;
        bus(1'b1, `TCPSC_OFS_TDL, t);
        bus(1'b1, `TCPSC_OFS_PKL, p);
        bus(1'b1, `TCPSC_OFS_PUSH, {31'h0, ps});
        bus(1'b1, `TCPSC_OFS_CMD, {30'h0, `TCPSC_CMD_SEND});
        repeat (20) @(posedge hclk);
        chk("held", 32'(!late), 32'(lens.size() != 0));
        pay <= 32'h0001_0000;
        idle();
        chk("frames", 32'(n + (t % p == 0 ? 0 : ps ? 1 : 2)), 32'(lens.size()));
        foreach (lens[i]) chk("len", i < n ? p : t % p, lens[i]);
        foreach (acks[i]) chk("acked", 32'(i >= n), 32'(acks[i] != 0));
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("eng_rst", `TCPSC_OFS_RESET, 32'h1);
        rd("unmapped", 8'h3C, 32'h0);
        for (int k = 0; k < 3; k++) begin
            int r;
            r = (k + 1) % 3;
            bus(1'b1, `TCPSC_OFS_RESET, 32'h1);
            bus(1'b1, `TCPSC_OFS_ROLE, 32'(r));
            bus(1'b1, `TCPSC_OFS_PMAC_LO, 32'h3344_5566);
            bus(1'b1, `TCPSC_OFS_LIP, 32'hC0A8_0001);
            bus(1'b1, `TCPSC_OFS_PIP, 32'hC0A8_0002);
            bus(1'b1, `TCPSC_OFS_RESET, 32'h0);
            repeat (4) @(posedge hclk);
            arp_in <= r == 1;
            @(posedge hclk);
            arp_in <= 1'b0;
            idle();
            chk("peer_mac", r == 2 ? 32'h3344_5566 : 32'h0C0D_0E0F, net.peer_mac[31:0]);
            chk("lip", 32'hC0A8_0001, net.local_ip);
            chk("pip", 32'hC0A8_0002, net.peer_ip);
            chk("resp", 32'h0, {31'h0, hresp});
        end
        syn_in <= 1'b1;
        @(posedge hclk);
        syn_in <= 1'b0;
        upw(1'b1);
        rd("status", `TCPSC_OFS_STATUS, 32'h2);
        snd(32'h40, 32'h10, 1'b0, 1'b1);
        snd(32'h46, 32'h10, 1'b0, 1'b0);
        slow <= 1'b1;
        snd(32'h46, 32'h10, 1'b1, 1'b0);
        fin_in <= 1'b1;
        @(posedge hclk);
        fin_in <= 1'b0;
        upw(1'b0);
        bus(1'b1, `TCPSC_OFS_CMD, {30'h0, `TCPSC_CMD_OPEN});
        idle();
        upw(1'b1);
        bus(1'b1, `TCPSC_OFS_CMD, {30'h0, `TCPSC_CMD_CLOSE});
        idle();
        upw(1'b0);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        report_and_stop();
    end
endmodule

// ===== testbench/tcpsc_peer.sv
// Remote peer model: answers link frames, cumulative delayed ack
`timescale 1ns/1ns
module tcpsc_peer (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire tcpsc_pkg::tcpsc_tx_type tx_req,
    input  wire logic                    slow,
    input  wire logic                    syn_in,
    input  wire logic                    fin_in,
    input  wire logic                    arp_in,
    output logic                         tx_ready,
    output tcpsc_pkg::tcpsc_rx_type      rx_evt
);
    logic [31:0] end_q;
    logic [3:0]  qt_q;
    logic        pend_q;
    logic        fin_q;
    logic        ph_q;
    assign tx_ready = (!slow || ph_q) && qt_q != 4'h8;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rx_evt, end_q, qt_q, pend_q, fin_q, ph_q} <= '0;
        end else begin
            rx_evt <= '0;
            rx_evt.src_mac <= 48'h0A0B_0C0D_0E0F;
            rx_evt.syn <= syn_in;
            rx_evt.arp_request <= arp_in;
            ph_q <= !ph_q;
            qt_q <= qt_q + 4'h1;
            if (fin_in) begin
                rx_evt.fin <= 1'b1;
                fin_q <= 1'b1;
            end
            if (tx_req.valid && tx_ready) begin
                rx_evt.ack_num <= tx_req.seq + 32'h1;
                case (tx_req.kind)
                    tcpsc_pkg::K_ARP_REQ: rx_evt.arp_reply <= 1'b1;
                    tcpsc_pkg::K_SYN:     rx_evt.syn_ack <= 1'b1;
                    tcpsc_pkg::K_SYN_ACK: rx_evt.ack <= 1'b1;
                    tcpsc_pkg::K_FIN: begin
                        rx_evt.ack <= fin_q;
                        rx_evt.fin <= !fin_q;
                        fin_q <= 1'b0;
                    end
                    tcpsc_pkg::K_DATA: begin
                        end_q <= tx_req.seq + tx_req.len;
                        pend_q <= 1'b1;
                        qt_q <= 4'h0;
                    end
                    default: ;
                endcase
            end
            if (pend_q && qt_q == 4'h8) begin
                rx_evt.ack <= 1'b1;
                rx_evt.ack_num <= end_q;
                pend_q <= 1'b0;
            end
        end
    end
endmodule
